// ===== core/shift_store_pkg.sv
// shared constants and types of the eight-bit shift and storage register
package shift_store_pkg;
   // ------------------------------------------------------------
   // widths and depths
   // ------------------------------------------------------------
   localparam int unsigned DATA_W = 8;
   localparam int unsigned BUF_DEPTH = 2;
   localparam int unsigned ADDR_W = 12;

   // ------------------------------------------------------------
   // register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_STATE = 12'h004;
   localparam logic [11:0] OFF_CAPTURE = 12'h008;
   localparam logic [11:0] OFF_PRESET = 12'h00c;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int unsigned CTRL_SW_EN_BIT = 0;
   localparam int unsigned CTRL_MODE_LO_BIT = 1;
   localparam int unsigned CTRL_MODE_HI_BIT = 2;
   localparam int unsigned STATE_MODE_LO_BIT = 8;
   localparam int unsigned STATE_OE_BIT = 10;
   localparam int unsigned STATE_ROOM_BIT = 11;
   localparam int unsigned CAPTURE_VALID_BIT = 8;

   // ------------------------------------------------------------
   // values after reset
   // ------------------------------------------------------------
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

   // ------------------------------------------------------------
   // operating modes
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_HOLD,
      MODE_SHIFT_RIGHT,
      MODE_SHIFT_LEFT,
      MODE_LOAD
   } shift_mode_e;
endpackage

// ===== core/capture_if.sv
// word path between the shift register and its capture buffer
`timescale 1ns/100ps
interface capture_if;
   logic push_valid;
   logic push_ready;
   logic [7:0] push_data;
   logic pop_valid;
   logic pop_ready;
   logic [7:0] pop_data;

   modport producer (
      output push_valid,
      output push_data,
      output pop_ready,
      input push_ready,
      input pop_valid,
      input pop_data
   );

   modport store (
      input push_valid,
      input push_data,
      input pop_ready,
      output push_ready,
      output pop_valid,
      output pop_data
   );
endinterface

// ===== core/capture_buffer.sv
// two-entry capture buffer, head word and flags held in flip-flops
`timescale 1ns/100ps
module capture_buffer (
   // clock and control
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic ce,
   // word path
   capture_if.store port
);
   typedef struct packed {
      logic [7:0] head;
      logic [7:0] tail;
      logic head_valid;
      logic tail_valid;
      logic room;
   } buf_s;

   buf_s st;
   buf_s next_st;
   logic do_pop;
   logic do_push;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_st = st;
      do_pop = port.pop_ready & st.head_valid;
      do_push = port.push_valid & st.room;
      if (do_pop) begin
         next_st.head = st.tail;
         next_st.head_valid = st.tail_valid;
         next_st.tail_valid = 1'b0;
      end
      if (do_push) begin
         if (!next_st.head_valid) begin
            next_st.head = port.push_data;
            next_st.head_valid = 1'b1;
         end else begin
            next_st.tail = port.push_data;
            next_st.tail_valid = 1'b1;
         end
      end
      next_st.room = ~next_st.tail_valid;
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st <= '{head: shift_store_pkg::DATA_RESET, tail: shift_store_pkg::DATA_RESET,
                 head_valid: 1'b0, tail_valid: 1'b0, room: 1'b1};
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign port.push_ready = st.room;
   assign port.pop_valid = st.head_valid;
   assign port.pop_data = st.head;
endmodule // capture_buffer

// ===== core/shift_store_reg.sv
// eight-bit universal shift and storage register with apb access
// Operation
// R1 - eight-bit register on shared bidirectional parallel pins
// R2 - two selects choose shift, load or hold
// R3 - contents change only on rising clock edge
// R4 - low master clear empties register immediately
// R5 - either output disable floats pins, operation continues; here the drivers go off only at the next clock edge with ce high
// R6 - separate serial inputs and outputs for chaining
// R7 - mode code 00 hold, 11 load
`timescale 1ns/100ps
module shift_store_reg (
   // clock, reset and enable
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic ce,
   input wire logic master_clear_n,
   // mode selection
   input wire logic mode_select_low,
   input wire logic mode_select_high,
   // parallel pins
   input wire logic [7:0] io_in,
   output logic [7:0] io_out,
   output logic [7:0] io_oe,
   input wire logic out_en_a_n,
   input wire logic out_en_b_n,
   // serial chaining
   input wire logic serial_in_right,
   input wire logic serial_in_left,
   output logic serial_out_low,
   output logic serial_out_high,
   // capture flow
   output logic capture_ready,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   typedef struct packed {
      logic [7:0] q;
      logic [7:0] oe;
      logic sw_en;
      logic [1:0] sw_mode;
      logic ready;
      logic err;
      logic [31:0] rdata;
      logic ser_low;
      logic ser_high;
   } state_s;

   localparam state_s RESET_ST = '{q: shift_store_pkg::DATA_RESET, oe: 8'h00, sw_en: 1'b0,
                                   sw_mode: 2'h0, ready: 1'b0, err: 1'b0,
                                   rdata: shift_store_pkg::RDATA_RESET,
                                   ser_low: 1'b0, ser_high: 1'b0};

   state_s st;
   state_s next_st;
   shift_store_pkg::shift_mode_e mode;
   logic apb_setup;
   logic apb_done;
   logic wr_ctrl;
   logic wr_preset;
   logic rd_capture;
   logic [31:0] read_word;
   logic captured;

   capture_if cap ();

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic shift_store_pkg::shift_mode_e decode_mode(input logic sel_low, input logic sel_high);
      shift_store_pkg::shift_mode_e m;
      m = shift_store_pkg::MODE_HOLD;
      unique case ({sel_high, sel_low})
         2'h0: m = shift_store_pkg::MODE_HOLD; // see R7
         2'h1: m = shift_store_pkg::MODE_SHIFT_RIGHT; // see R7
         2'h2: m = shift_store_pkg::MODE_SHIFT_LEFT; // see R7
         2'h3: m = shift_store_pkg::MODE_LOAD; // see R7
      endcase
      return m;
   endfunction

   function automatic logic addr_mapped(input logic [11:0] a);
      return (a == shift_store_pkg::OFF_CTRL) || (a == shift_store_pkg::OFF_STATE) ||
             (a == shift_store_pkg::OFF_CAPTURE) || (a == shift_store_pkg::OFF_PRESET);
   endfunction

   // ------------------------------------------------------------
   // capture buffer
   // ------------------------------------------------------------
   capture_buffer u_capture (
      .clk_sys(clk_sys),
      .reset(reset),
      .ce(ce),
      .port(cap.store)
   );

   // ------------------------------------------------------------
   // mode and read mux
   // ------------------------------------------------------------
   always_comb begin
      // software may take over the selects for bench or bring-up use
      if (st.sw_en) begin
         mode = decode_mode(st.sw_mode[0], st.sw_mode[1]); // see R2
      end else begin
         mode = decode_mode(mode_select_low, mode_select_high); // see R2
      end
   end

   always_comb begin
      read_word = 32'h0000_0000;
      unique case (paddr)
         shift_store_pkg::OFF_CTRL: begin
            read_word[shift_store_pkg::CTRL_SW_EN_BIT] = st.sw_en;
            read_word[shift_store_pkg::CTRL_MODE_LO_BIT] = st.sw_mode[0];
            read_word[shift_store_pkg::CTRL_MODE_HI_BIT] = st.sw_mode[1];
         end
         shift_store_pkg::OFF_STATE: begin
            read_word[7:0] = st.q;
            read_word[shift_store_pkg::STATE_MODE_LO_BIT +: 2] = mode;
            read_word[shift_store_pkg::STATE_OE_BIT] = st.oe[0];
            read_word[shift_store_pkg::STATE_ROOM_BIT] = cap.push_ready;
         end
         shift_store_pkg::OFF_CAPTURE: begin
            read_word[7:0] = cap.pop_data;
            read_word[shift_store_pkg::CAPTURE_VALID_BIT] = cap.pop_valid;
         end
         default: begin
            read_word = 32'h0000_0000;
         end
      endcase
   end

   // ------------------------------------------------------------
   // bus strobes
   // ------------------------------------------------------------
   // done marks the completion edge, one cycle after the access phase starts
   assign apb_setup = psel & penable & ~st.ready;
   assign apb_done = psel & penable & st.ready;
   assign wr_ctrl = apb_done & pwrite & (paddr == shift_store_pkg::OFF_CTRL);
   assign wr_preset = apb_done & pwrite & (paddr == shift_store_pkg::OFF_PRESET);
   assign rd_capture = apb_done & ~pwrite & (paddr == shift_store_pkg::OFF_CAPTURE);

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_st = st;
      captured = 1'b0;

      // apb answer one cycle into the access phase
      next_st.ready = apb_setup;
      next_st.err = apb_setup & ~addr_mapped(paddr);
      next_st.rdata = (apb_setup & ~pwrite) ? read_word : 32'h0000_0000;

      unique case (mode)
         shift_store_pkg::MODE_HOLD: begin
            next_st.q = st.q; // see R2
         end
         shift_store_pkg::MODE_SHIFT_RIGHT: begin
            next_st.q = {st.q[6:0], serial_in_right}; // see R2, R6
         end
         shift_store_pkg::MODE_SHIFT_LEFT: begin
            next_st.q = {serial_in_left, st.q[7:1]}; // see R2, R6
         end
         shift_store_pkg::MODE_LOAD: begin
            // a load waits while the capture buffer is full
            if (cap.push_ready) begin
               next_st.q = io_in; // see R1, R2
               captured = 1'b1;
            end
         end
      endcase

      // a preset write wins over the clocked mode of the same cycle
      if (wr_ctrl) begin
         next_st.sw_en = pwdata[shift_store_pkg::CTRL_SW_EN_BIT];
         next_st.sw_mode = {pwdata[shift_store_pkg::CTRL_MODE_HI_BIT],
                            pwdata[shift_store_pkg::CTRL_MODE_LO_BIT]};
      end
      if (wr_preset) begin
         next_st.q = pwdata[7:0];
      end

      // drivers off when disabled or while the pins act as inputs
      next_st.oe = {8{~(out_en_a_n | out_en_b_n) & (mode != shift_store_pkg::MODE_LOAD)}}; // see R5, R7
      next_st.ser_low = next_st.q[0]; // see R6
      next_st.ser_high = next_st.q[7]; // see R6
   end

   assign cap.push_valid = captured;
   assign cap.push_data = io_in;
   assign cap.pop_ready = rd_capture;

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge master_clear_n) begin // see R3
      if (!master_clear_n) begin
         st <= RESET_ST; // see R4
      end else if (reset) begin
         st <= RESET_ST;
      end else if (ce) begin
         st <= next_st; // see R3
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign io_out = st.q; // see R1
   assign io_oe = st.oe; // see R5
   assign serial_out_low = st.ser_low;
   assign serial_out_high = st.ser_high;
   assign capture_ready = cap.push_ready;
   assign prdata = st.rdata;
   assign pready = st.ready;
   assign pslverr = st.err;
endmodule // shift_store_reg

// ===== tb/shift_store_checker.sv
// port assertions for the shift and storage register
`timescale 1ns/100ps
module shift_store_checker (
   // clock and clears
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic ce,
   input wire logic master_clear_n,
   // pins
   input wire logic mode_select_low,
   input wire logic mode_select_high,
   input wire logic [7:0] io_in,
   input wire logic [7:0] io_out,
   input wire logic [7:0] io_oe,
   input wire logic out_en_a_n,
   input wire logic out_en_b_n,
   input wire logic serial_in_right,
   input wire logic serial_in_left,
   input wire logic serial_out_low,
   input wire logic serial_out_high,
   input wire logic capture_ready,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready
);
   logic sw_on;
   wire [1:0] m = {mode_select_high, mode_select_low};
   wire off = out_en_a_n || out_en_b_n || m == 2'b11;
   // mode and driver checks start only on an enabled edge outside any clear, with the pins in control
   wire run = ce && !reset && master_clear_n && !sw_on;

   // software override of the selects hides the pin mode from these checks
   always_ff @(posedge clk_sys or negedge master_clear_n) begin
      if (!master_clear_n) begin
         sw_on <= 1'b0;
      end else if (reset) begin
         sw_on <= 1'b0;
      end else if (ce && psel && penable && pready && pwrite && paddr == shift_store_pkg::OFF_CTRL) begin
         sw_on <= pwdata[shift_store_pkg::CTRL_SW_EN_BIT];
      end
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset || !master_clear_n);
   sequence setup_s; psel && !penable; endsequence
   sequence access_s; psel && penable && !pready; endsequence
   shr_a: assert property (run && !psel && m == 2'b01 |=> io_out == 8'({$past(io_out), $past(serial_in_right)}))
      else $error("shift right wrong");
   shl_a: assert property (run && !psel && m == 2'b10 |=> io_out == {$past(serial_in_left), $past(io_out[7:1])})
      else $error("shift left wrong");
   load_a: assert property (run && !psel && m == 2'b11 && capture_ready |=> io_out == $past(io_in))
      else $error("load wrong");
   hold_a: assert property (run && !psel && m == 2'b00 |=> $stable(io_out))
      else $error("hold changed data");
   oe_off_a: assert property (run && off |=> io_oe == 8'h00)
      else $error("pins still driven");
   oe_on_a: assert property (run && !off |=> io_oe == 8'hff)
      else $error("pins not driven");
   serial_a: assert property (serial_out_low == io_out[0] && serial_out_high == io_out[7])
      else $error("serial out wrong");
   clear_a: assert property (disable iff (reset) !master_clear_n |-> io_out == 8'h00 && io_oe == 8'h00)
      else $error("clear failed");
   apb_answer_a: assert property (setup_s ##1 access_s |=> pready)
      else $error("apb answer late");
endmodule // shift_store_checker

bind shift_store_reg shift_store_checker u_chk (.*);

// ===== tb/pin_bus_partner.sv
// far-side bus party sharing the parallel pins
`timescale 1ns/100ps
module pin_bus_partner (
   // pin levels
   input wire logic [7:0] io_out,
   input wire logic [7:0] io_oe,
   input wire logic [7:0] drive_val,
   output logic [7:0] io_in
);
   // the far side drives only the bits the register has released
   assign io_in = (io_out & io_oe) | (drive_val & ~io_oe);
endmodule // pin_bus_partner

// ===== tb/tb_top.sv
// self-checking bench for the shift and storage register
`timescale 1ns/100ps
module tb_top;
   logic clk_sys, reset, ce, master_clear_n, mode_select_low, mode_select_high, room;
   logic out_en_a_n, out_en_b_n, serial_in_right, serial_in_left, serial_out_low, serial_out_high;
   logic capture_ready, psel, penable, pwrite, pready, pslverr;
   logic [7:0] io_in, io_out, io_oe, drive_val, exp_q, exp_oe;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [32:0] rd;
   logic [7:0] fq[$];
   logic [2:0] sw_ctl;
   int err_total, checks_done;

   shift_store_reg u_dut (.*);
   pin_bus_partner u_bus (.*);

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   task automatic chk_pin(input logic [7:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_bus(input logic [32:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic complete_run;
      if (err_total == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   function automatic logic [7:0] next_q(input logic [1:0] m, input logic [7:0] q, d, input logic r, l, ok);
      case (m)
         2'b01: return {q[6:0], r};
         2'b10: return {l, q[7:1]};
         2'b11: return ok ? d : q;
         default: return q;
      endcase
   endfunction

   // one pin cycle; checks what the previous cycle left behind
   task automatic step(input logic [1:0] m, input logic [1:0] en_n);
      logic [1:0] eff;
      mode_select_high <= m[1];
      mode_select_low <= m[0];
      out_en_a_n <= en_n[0];
      out_en_b_n <= en_n[1];
      serial_in_right <= 1'($urandom);
      serial_in_left <= 1'($urandom);
      drive_val <= 8'($urandom);
      @(negedge clk_sys);
      chk_pin(io_out, exp_q);
      chk_pin(io_oe, exp_oe);
      chk_pin({6'h00, serial_out_high, serial_out_low}, {6'h00, exp_q[7], exp_q[0]});
      chk_pin({7'h00, capture_ready}, {7'h00, fq.size() < 2});
      room = fq.size() < 2;
      // software selects override the pins; a low clock enable freezes everything
      eff = sw_ctl[0] ? sw_ctl[2:1] : m;
      if (ce) begin
         exp_q = next_q(eff, exp_q, io_in, serial_in_right, serial_in_left, room);
         if (eff == 2'b11 && room)
            fq.push_back(io_in);
         exp_oe = (en_n == 2'b00 && eff != 2'b11) ? 8'hff : 8'h00;
      end
      @(posedge clk_sys);
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      rd = {pslverr, prdata};
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask

   initial begin
      repeat (5000) @(posedge clk_sys);
      err_total++;
      complete_run();
   end

   initial begin
      {ce, master_clear_n, reset} = 3'b111;
      {mode_select_high, mode_select_low, out_en_a_n, out_en_b_n} = 4'h0;
      {serial_in_right, serial_in_left, psel, penable, pwrite} = 5'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      drive_val = 8'h00;
      err_total = 0;
      checks_done = 0;
      exp_q = 8'h00;
      exp_oe = 8'h00;
      sw_ctl = 3'h0;
      repeat (12) @(posedge clk_sys);
      reset <= 1'b0;
      void'($urandom(32'hc558));
      step(2'b00, 2'b00);
      apb(1'b1, shift_store_pkg::OFF_CTRL, 32'h0000_0006);
      apb(1'b0, shift_store_pkg::OFF_CTRL, 32'h0);
      chk_bus(rd, 33'h0_0000_0006);
      apb(1'b0, 12'h010, 32'h0);
      chk_bus(rd, 33'h1_0000_0000);
      // software holds the register although the pins ask for a load
      sw_ctl = 3'h1;
      apb(1'b1, shift_store_pkg::OFF_CTRL, 32'h0000_0001);
      step(2'b11, 2'b00);
      apb(1'b0, shift_store_pkg::OFF_STATE, 32'h0);
      chk_bus(rd, {21'h0, fq.size() < 2, exp_oe[0], 2'b00, exp_q});
      step(2'b00, 2'b00);
      sw_ctl = 3'h0;
      apb(1'b1, shift_store_pkg::OFF_CTRL, 32'h0000_0000);
      // random pin traffic; the capture buffer fills and refuses loads
      for (int i = 0; i < 300; i++) begin
         step(2'($urandom), ($urandom % 4 == 0) ? 2'($urandom) : 2'b00);
         if (i % 12 == 11) begin
            step(2'b00, 2'b00);
            if (fq.size() > 0) begin
               apb(1'b0, shift_store_pkg::OFF_CAPTURE, 32'h0);
               chk_bus(rd, {24'h0, 1'b1, fq.pop_front()});
            end
            apb(1'b0, shift_store_pkg::OFF_STATE, 32'h0);
            chk_bus(rd, {21'h0, fq.size() < 2, exp_oe[0], 2'b00, exp_q});
         end
      end
      step(2'b00, 2'b00);
      while (fq.size() > 0) begin
         apb(1'b0, shift_store_pkg::OFF_CAPTURE, 32'h0);
         chk_bus(rd, {24'h0, 1'b1, fq.pop_front()});
      end
      apb(1'b0, shift_store_pkg::OFF_CAPTURE, 32'h0);
      chk_pin({7'h00, rd[8]}, 8'h00);
      // clock enable low freezes shifting, loading and the drivers
      ce <= 1'b0;
      step(2'b01, 2'b11);
      step(2'b11, 2'b00);
      ce <= 1'b1;
      step(2'b00, 2'b00);
      // preset, then an asynchronous clear between edges
      apb(1'b1, shift_store_pkg::OFF_PRESET, 32'h0000_00a5);
      exp_q = 8'ha5;
      step(2'b01, 2'b00);
      master_clear_n <= 1'b0;
      @(negedge clk_sys);
      chk_pin(io_out, 8'h00);
      chk_pin(io_oe, 8'h00);
      @(posedge clk_sys);
      master_clear_n <= 1'b1;
      exp_q = 8'h00;
      exp_oe = 8'h00;
      step(2'b10, 2'b00);
      step(2'b00, 2'b00);
      complete_run();
   end
endmodule // tb_top
